// ===== hdl/timer_counter_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the timer/counter
// Assumes: byte-wide register port with a small address space
// Notes: included by the package and by every design file
`ifndef TIMER_COUNTER_DEFS_SVH
`define TIMER_COUNTER_DEFS_SVH

// register offsets
`define OFS_TIMER_COUNT     8'h01
`define OFS_COMP_CTRL_SMALL 8'h07
`define OFS_COMP_CTRL_LARGE 8'h08
`define OFS_TIMER_CONFIG    8'h10
`define OFS_PIN_DIRECTION   8'h11

// timer_config_reg field positions
`define CFG_SRC_SEL_BIT     5
`define CFG_EDGE_SEL_BIT    4
`define CFG_PSA_BIT         3

// comparator_control_reg field positions
`define CMP_OUT_BIT         7
`define CMP_DRIVE_EN_N_BIT  6
`define CMP_POLARITY_BIT    5
`define CMP_ROUTE_BIT       4

// bit of pin_direction_reg that steers external_count_pin
`define PIN_CNT_BIT         2

// reset values
`define RST_TIMER_COUNT     8'h00
`define RST_COMP_CTRL       8'hff
`define RST_TIMER_CONFIG    8'hff
`define RST_PIN_DIRECTION   8'hff

// timing counts: four oscillator phases per instruction cycle
`define PHASES_PER_CYCLE    4
`define PHASE_Q2            2'h1
`define PHASE_Q4            2'h3
`define WRITE_INHIBIT_TICKS 2'h2

`endif

// ===== hdl/timer_counter_pkg.sv
// Purpose: shared types of the timer/counter
// Assumes: constants live in timer_counter_defs.svh
// Notes: field order of the structs matches the register bit order
`include "timer_counter_defs.svh"

package timer_counter_pkg;

	// timer_config_reg, bit 7 down to bit 0
	typedef struct packed {
		logic       wake_on_change;
		logic       pull_up_n;
		logic       count_source_select;
		logic       edge_select;
		logic       prescaler_assign;
		logic [2:0] prescale_ratio;
	} timer_config_t;

	// comparator_control_reg, bit 7 down to bit 0
	typedef struct packed {
		logic       comparator_out;
		logic       comparator_pin_drive_enable_n;
		logic       polarity;
		logic       comparator_count_route;
		logic       comparator_on;
		logic       neg_ref_sel;
		logic       pos_ref_sel;
		logic       wake_n;
	} comp_ctrl_t;

	// where the count comes from
	typedef enum logic [1:0] {
		MODE_TIMER     = 2'b00,
		MODE_PIN       = 2'b01,
		MODE_COMP_INT  = 2'b10,
		MODE_PIN_DRIVE = 2'b11
	} count_mode_t;

endpackage

// ===== hdl/count_prescaler.sv
// Purpose: divide-by-power-of-two prescaler shared between timer and watchdog
// Assumes: step_i is a one-cycle pulse per counted source event
// Notes: count is private; only the selected stage leaves the module
`include "timer_counter_defs.svh"

module count_prescaler
	import timer_counter_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clear_i,
	input  wire logic       step_i,
	input  wire logic [2:0] ratio_i,
	output logic            out_o
);

	logic [WIDTH-1:0] cnt_q;

	// binary count stands in for the ripple chain: each stage is a square wave
	// of half the previous rate, so the output stays symmetrical
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else if (clear_i)
			cnt_q <= '0;
		else if (step_i)
			cnt_q <= cnt_q + 1'b1;
	end

	// ratio 0 takes stage 0, a divide by 2; ratio 7 divides by 256
	assign out_o = cnt_q[ratio_i];

	property p_presc_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		clear_i |=> (cnt_q == '0);
	endproperty
	a_presc_clear: assert property (p_presc_clear)
		else $error("prescaler not cleared after timer write");

endmodule

// ===== hdl/timer_counter.sv
// Purpose: 8-bit timer/counter with prescaler, edge select and comparator source
// Assumes: ref_clk_i is the oscillator; four of its periods form one instruction cycle
// Notes: pin and comparator inputs pass a two-stage synchroniser before use
// Function
// - count lives in an 8-bit register that software reads and writes
// - source select clear gives timer mode, one step per instruction cycle
// - a count write holds the count for the next two increment cycles
// - source select, route and drive-enable-n set: count edges of the count pin
// - edge select zero counts rising edges, one counts falling edges
// - source select set, route clear: count comparator internally, drive bit ignored
// - source select and route set, drive-enable-n clear: comparator drives the pin, pin still counted
// - prescaler serves timer or watchdog; assign bit clear gives it to timer
// - prescaler count can never be read or loaded by software
// - prescaler divides by a power of two from 2 to 256
// - source select set overrides the direction bit of the count pin
// - without prescaler the external input is the prescaler output
// - prescaler output is sampled in phases two and four of each cycle
// - counter advances only some time after the synchronised edge
// - prescaler divides the external input, output is symmetrical
// - a count write clears the prescaler while it serves the timer
// - assign bit and three ratio bits form config bits three down to zero
// - any reset clears the prescaler count
`include "timer_counter_defs.svh"

module timer_counter
	import timer_counter_pkg::*;
#(
	parameter int PRESCALE_WIDTH = 8
)(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       comparator_raw_i,
	input  wire logic       pin_out_data_i,
	input  wire logic       external_count_pin_i,
	output logic            external_count_pin_o,
	output logic            external_count_pin_oe_o
);

	// software registers
	logic [7:0]    timer_count_q;
	timer_config_t timer_config_q;
	comp_ctrl_t    comp_ctrl_q;
	logic [7:0]    pin_direction_q;
	logic [7:0]    rdata_q;

	// phase, synchronisers and sampling path
	logic [1:0]    phase_q;
	logic          pin_s1_q;
	logic          pin_s2_q;
	logic          comp_s1_q;
	logic          comp_s2_q;
	logic          level_q;
	logic          sample_q;
	logic          pend_q;
	logic [1:0]    inhibit_q;
	logic          pin_o_q;
	logic          pin_oe_q;

	// combinational helpers
	count_mode_t   mode;
	logic          inst_tick;
	logic          count_wr;
	logic          comp_level;
	logic          src_level;
	logic          src_rise;
	logic          presc_step;
	logic          presc_clear;
	logic          presc_out;
	logic          sync_out;
	logic          sample_phase;
	logic          sample_rise;
	logic          count_event;

	// decode the count source from the two control registers
	function automatic count_mode_t decode_mode(input timer_config_t cfg,
		input comp_ctrl_t cmp);
		if (!cfg.count_source_select)
			return MODE_TIMER;
		else if (!cmp.comparator_count_route)
			return MODE_COMP_INT;
		else if (cmp.comparator_pin_drive_enable_n)
			return MODE_PIN;
		else
			return MODE_PIN_DRIVE;
	endfunction

	// address match used by both the write and the read decode
	function automatic logic is_comp_addr(input logic [7:0] a);
		return (a == `OFS_COMP_CTRL_SMALL) || (a == `OFS_COMP_CTRL_LARGE);
	endfunction

	assign mode      = decode_mode(timer_config_q, comp_ctrl_q);
	assign inst_tick = (phase_q == `PHASE_Q4);
	assign count_wr  = reg_wr_i && (reg_addr_i == `OFS_TIMER_COUNT);

	// instruction-cycle phase counter, Q1..Q4 as 0..3
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end

	// two-stage synchronisers; the first stage feeds only the second
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pin_s1_q  <= 1'b0;
			pin_s2_q  <= 1'b0;
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q  <= external_count_pin_i;
			pin_s2_q  <= pin_s1_q;
			comp_s1_q <= comparator_raw_i;
			comp_s2_q <= comp_s1_q;
		end
	end

	// comparator output after polarity: one means not inverted
	assign comp_level = comp_ctrl_q.polarity ? comp_s2_q : ~comp_s2_q;

	// pick the counted level; inverting it turns falling edges into rising ones
	always_comb
	begin
		case (mode)
			MODE_PIN:       src_level = pin_s2_q;
			MODE_PIN_DRIVE: src_level = pin_s2_q;
			MODE_COMP_INT:  src_level = comp_level;
			default:        src_level = 1'b0;
		endcase
		src_level = src_level ^ timer_config_q.edge_select;
	end

	// remember the last level to find the counted edge
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			level_q <= 1'b0;
		else
			level_q <= src_level;
	end

	assign src_rise = src_level && !level_q;

	// prescaler steps on instruction cycles in timer mode, on edges otherwise;
	// it only runs while given to the timer, the watchdog side is elsewhere
	assign presc_step  = !timer_config_q.prescaler_assign &&
		((mode == MODE_TIMER) ? inst_tick : src_rise);
	assign presc_clear = count_wr && !timer_config_q.prescaler_assign;

	count_prescaler #(
		.WIDTH     (PRESCALE_WIDTH)
	) u_prescaler (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clear_i   (presc_clear),
		.step_i    (presc_step),
		.ratio_i   (timer_config_q.prescale_ratio),
		.out_o     (presc_out)
	);

	// with no prescaler the edge-selected input itself is what gets sampled
	assign sync_out = timer_config_q.prescaler_assign ? src_level : presc_out;

	// sample only in Q2 and Q4, so pulses shorter than two phases may be lost
	assign sample_phase = (phase_q == `PHASE_Q2) || (phase_q == `PHASE_Q4);
	assign sample_rise  = sample_phase && sync_out && !sample_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			sample_q <= 1'b0;
		else if (sample_phase)
			sample_q <= sync_out;
	end

	// a sampled edge waits for the end of the instruction cycle; a new edge
	// in the very cycle that consumes the old one is kept, not lost
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			pend_q <= 1'b0;
		else if (sample_rise)
			pend_q <= 1'b1;
		else if (inst_tick)
			pend_q <= 1'b0;
	end

	// direct timer mode steps every cycle; all other paths go through pend
	assign count_event = inst_tick && ((mode == MODE_TIMER &&
		timer_config_q.prescaler_assign) || pend_q);

	// write-hold window counted in increment cycles
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			inhibit_q <= 2'h0;
		else if (count_wr)
			inhibit_q <= `WRITE_INHIBIT_TICKS;
		else if (inst_tick && inhibit_q != 2'h0)
			inhibit_q <= inhibit_q - 2'h1;
	end

	// the count: a write wins over an increment in the same cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			timer_count_q <= `RST_TIMER_COUNT;
		else if (count_wr)
			timer_count_q <= reg_wdata_i;
		else if (count_event && inhibit_q == 2'h0)
			timer_count_q <= timer_count_q + 8'h01;
	end

	// configuration registers; the prescaler has no address at all
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			timer_config_q  <= `RST_TIMER_CONFIG;
			pin_direction_q <= `RST_PIN_DIRECTION;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `OFS_TIMER_CONFIG)
				timer_config_q  <= reg_wdata_i;
			if (reg_addr_i == `OFS_PIN_DIRECTION)
				pin_direction_q <= reg_wdata_i;
		end
	end

	// comparator control: bit 7 is the live comparator output, not writable
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			comp_ctrl_q <= `RST_COMP_CTRL;
		else
		begin
			comp_ctrl_q.comparator_out <= comp_level;
			if (reg_wr_i && is_comp_addr(reg_addr_i))
				comp_ctrl_q[`CMP_DRIVE_EN_N_BIT:0] <= reg_wdata_i[`CMP_DRIVE_EN_N_BIT:0];
		end
	end

	// read data stand for exactly one cycle after the read strobe;
	// write-only and unmapped addresses read as zero
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			rdata_q <= 8'h00;
		else if (reg_rd_i && reg_addr_i == `OFS_TIMER_COUNT)
			rdata_q <= timer_count_q;
		else if (reg_rd_i && is_comp_addr(reg_addr_i))
			rdata_q <= comp_ctrl_q;
		else
			rdata_q <= 8'h00;
	end

	// pin drive: comparator drive, forced input, or plain port direction
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pin_o_q  <= 1'b0;
			pin_oe_q <= 1'b0;
		end
		else if (mode == MODE_PIN_DRIVE)
		begin
			pin_o_q  <= comp_level;
			pin_oe_q <= 1'b1;
		end
		else if (timer_config_q.count_source_select)
		begin
			pin_o_q  <= 1'b0;
			pin_oe_q <= 1'b0;
		end
		else
		begin
			pin_o_q  <= pin_out_data_i;
			pin_oe_q <= !pin_direction_q[`PIN_CNT_BIT];
		end
	end

	assign reg_rdata_o             = rdata_q;
	assign external_count_pin_o    = pin_o_q;
	assign external_count_pin_oe_o = pin_oe_q;

	// a count write seen from the register port
	sequence s_count_write;
		reg_wr_i && reg_addr_i == `OFS_TIMER_COUNT;
	endsequence

	// the written value arrives with the hold fully armed, and the hold is still
	// open a cycle later even if an instruction tick has already used one step
	sequence s_hold_two;
		(timer_count_q == $past(reg_wdata_i) && inhibit_q == 2'h2) ##1 (inhibit_q != 2'h0);
	endsequence

	property p_write_load;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_count_write |=> s_hold_two;
	endproperty
	a_write_load: assert property (p_write_load)
		else $error("count write not loaded or hold not armed");

	property p_inhibit_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		(inhibit_q != 2'h0 && !count_wr) |=> $stable(timer_count_q);
	endproperty
	a_inhibit_hold: assert property (p_inhibit_hold)
		else $error("count moved inside write hold");

	property p_inhibit_len;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_count_write ##1 (!count_wr)[*8] ##1 (!count_wr) |-> (inhibit_q == 2'h0);
	endproperty
	a_inhibit_len: assert property (p_inhibit_len)
		else $error("write hold lasted beyond two increment cycles");

	property p_timer_step;
		@(posedge ref_clk_i) disable iff (rst_i)
		(mode == MODE_TIMER && timer_config_q.prescaler_assign && inst_tick
			&& inhibit_q == 2'h0 && !count_wr)
		|=> (timer_count_q == $past(timer_count_q) + 8'h01);
	endproperty
	a_timer_step: assert property (p_timer_step)
		else $error("timer mode did not step on instruction cycle");

	property p_wrap;
		@(posedge ref_clk_i) disable iff (rst_i)
		(timer_count_q == 8'hff && count_event && inhibit_q == 2'h0 && !count_wr)
		|=> (timer_count_q == 8'h00);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("count did not wrap to zero");

	property p_edge_delay;
		@(posedge ref_clk_i) disable iff (rst_i)
		(mode != MODE_TIMER && count_event) |-> $past(pend_q);
	endproperty
	a_edge_delay: assert property (p_edge_delay)
		else $error("counter advanced with no earlier sampled edge");

	property p_sample_phase;
		@(posedge ref_clk_i) disable iff (rst_i)
		$changed(sample_q) |-> ($past(phase_q) == `PHASE_Q2 ||
			$past(phase_q) == `PHASE_Q4);
	endproperty
	a_sample_phase: assert property (p_sample_phase)
		else $error("prescaler output sampled outside Q2 and Q4");

	property p_pin_override;
		@(posedge ref_clk_i) disable iff (rst_i)
		(timer_config_q.count_source_select && mode != MODE_PIN_DRIVE)
		|=> !external_count_pin_oe_o;
	endproperty
	a_pin_override: assert property (p_pin_override)
		else $error("count pin driven while source select overrides it");

	property p_pin_drive;
		@(posedge ref_clk_i) disable iff (rst_i)
		(mode == MODE_PIN_DRIVE) |=>
			(external_count_pin_oe_o && external_count_pin_o == $past(comp_level));
	endproperty
	a_pin_drive: assert property (p_pin_drive)
		else $error("comparator output not driven onto count pin");

	property p_presc_idle;
		@(posedge ref_clk_i) disable iff (rst_i)
		timer_config_q.prescaler_assign |=> $stable(u_prescaler.cnt_q);
	endproperty
	a_presc_idle: assert property (p_presc_idle)
		else $error("prescaler stepped while given to the watchdog");

endmodule

// ===== bench/count_source_model.sv
// Purpose: far-side stand-in for the count pin source and the comparator output
// Assumes: levels change only just after a rising clock edge
// Notes: the pin wire is resolved here; the block wins while it drives the pin
module count_source_model
	import timer_counter_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic drive_i,
	input  wire logic drive_en_i,
	output logic      pin_level_o,
	output logic      cmp_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic src_q;

	initial
	begin
		src_q = 1'b0;
		cmp_level_o = 1'b0;
	end

	// resolved pin level; the model never fights the block's own driver
	assign pin_level_o = drive_en_i ? drive_i : src_q;

	// steady level on the pin source
	task automatic set(input bit v);
		@(posedge ref_clk_i);
		src_q <= v;
	endtask

	// n full pulses, eight clocks high then eight low, far above two periods
	task automatic pulse(input int n, input bit on_cmp);
		for (int k = 0; k < 2 * n; k++)
		begin
			@(posedge ref_clk_i);
			if (on_cmp) cmp_level_o <= ~cmp_level_o;
			else src_q <= ~src_q;
			repeat (7) @(posedge ref_clk_i);
		end
	endtask
endmodule

// ===== bench/timer_counter_test.sv
// Purpose: self-checking bench of the timer/counter through its register port
// Assumes: phase counter runs from reset release, one tick every four clocks
// Notes: timed reads sit a whole number of ticks apart, so phase does not matter
`include "timer_counter_defs.svh"

module timer_counter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk_i;
	logic       rst_i;
	logic       reg_wr_i;
	logic       reg_rd_i;
	logic       pin_out_data_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic [7:0] reg_rdata_o;
	logic [7:0] seen;
	logic [7:0] first;
	logic       pin_o;
	logic       pin_oe;
	logic       pin_i;
	logic       cmp_raw;
	int         errors;
	int         tests_run;

	timer_counter dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .comparator_raw_i(cmp_raw),
		.pin_out_data_i(pin_out_data_i), .external_count_pin_i(pin_i),
		.external_count_pin_o(pin_o), .external_count_pin_oe_o(pin_oe)
	);

	count_source_model src (
		.ref_clk_i(ref_clk_i), .drive_i(pin_o), .drive_en_i(pin_oe),
		.pin_level_o(pin_i), .cmp_level_o(cmp_raw)
	);

	// 10 MHz oscillator
	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task automatic check(input logic [7:0] s, input logic [7:0] e, input string what);
		tests_run++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, s, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 seen = reg_rdata_o;
	endtask

	// clear, let any stale edge settle past the write hold, then count n pulses
	task automatic count_run(input bit on_cmp, input int n);
		idle(20);
		wr(`OFS_TIMER_COUNT, 8'h00);
		idle(20);
		src.pulse(n, on_cmp);
		if (!on_cmp) src.set(1'b1);
		idle(20);
		rd(`OFS_TIMER_COUNT);
	endtask

	task automatic conclude();
		$display("compares %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard, well beyond the roughly 4200 clocks the tests need
	initial
	begin
		#2000000;
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	initial
	begin
		rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		pin_out_data_i = 1'b1;
		errors = 0;
		tests_run = 0;
		idle(5);
		rst_i <= 1'b0;
		// reset values, write-only and unmapped places read zero
		rd(`OFS_TIMER_COUNT); check(seen, `RST_TIMER_COUNT, "count reset");
		rd(`OFS_COMP_CTRL_SMALL); check(seen, 8'h7f, "comparator ctrl reset");
		rd(`OFS_COMP_CTRL_LARGE); check(seen, 8'h7f, "comparator ctrl alias");
		rd(`OFS_TIMER_CONFIG); check(seen, 8'h00, "config write-only");
		rd(8'h20); check(seen, 8'h00, "unmapped read");
		check({7'h00, pin_oe}, 8'h00, "pin released at reset");
		$display("test reset done");

		// timer mode, prescaler on the watchdog side, pin as plain output
		wr(`OFS_TIMER_CONFIG, 8'hc8);
		wr(`OFS_PIN_DIRECTION, 8'h00);
		wr(`OFS_TIMER_COUNT, 8'hfe);
		rd(`OFS_TIMER_COUNT); check(seen, 8'hfe, "held after write");
		wr(`OFS_TIMER_COUNT, 8'hfe);
		idle(15);
		rd(`OFS_TIMER_COUNT); check(seen, 8'h00, "four ticks, two held");
		check({6'h00, pin_oe, pin_o}, 8'h03, "pin follows latch");
		$display("test timer done");

		// every prescale ratio: one step per 2^(r+1) ticks
		for (int r = 0; r < 8; r++)
		begin
			wr(`OFS_TIMER_CONFIG, {5'b00000, r[2:0]});
			wr(`OFS_TIMER_COUNT, 8'h00);
			idle(20);
			rd(`OFS_TIMER_COUNT);
			first = seen;
			idle((4 << (r + 1)) - 2);
			rd(`OFS_TIMER_COUNT);
			check(seen - first, 8'h01, "prescaled step");
		end
		// a count write restarts the divide-by-256, first rise 128 ticks later
		idle(500);
		wr(`OFS_TIMER_COUNT, 8'h40);
		idle(400);
		rd(`OFS_TIMER_COUNT); check(seen, 8'h40, "prescaler cleared");
		idle(400);
		rd(`OFS_TIMER_COUNT); check(seen, 8'h41, "first step after clear");
		$display("test prescaler done");

		// pin counter mode, both edges; pin ends high so rising sees one more
		for (int es = 0; es < 2; es++)
		begin
			src.set(1'b0);
			wr(`OFS_TIMER_CONFIG, 8'h28 | (es[0] ? 8'h10 : 8'h00));
			count_run(1'b0, 3);
			check(seen, 8'h04 - es[7:0], "pin edges");
			check({7'h00, pin_oe}, 8'h00, "direction overridden");
		end
		$display("test pin done");

		// comparator on the internal path, drive bit cleared but ignored
		wr(`OFS_TIMER_CONFIG, 8'h28);
		wr(`OFS_COMP_CTRL_SMALL, 8'h2f);
		count_run(1'b1, 3);
		check(seen, 8'h03, "comparator internal");
		check({7'h00, pin_oe}, 8'h00, "pin not driven");
		// comparator driven onto the pin and counted back through it
		wr(`OFS_COMP_CTRL_LARGE, 8'h3f);
		count_run(1'b1, 3);
		check(seen, 8'h03, "comparator via pin");
		check({6'h00, pin_oe, pin_o}, 8'h02, "pin driven with comparator");
		rd(`OFS_COMP_CTRL_SMALL); check(seen, 8'h3f, "comparator ctrl readback");
		$display("test comparator done");

		// pin edges through the prescaler at 1:2; five rises give three steps
		src.set(1'b0);
		wr(`OFS_COMP_CTRL_SMALL, 8'h7f);
		wr(`OFS_TIMER_CONFIG, 8'h20);
		count_run(1'b0, 4);
		check(seen, 8'h03, "pin through prescaler");
		check({7'h00, pin_oe}, 8'h00, "pin released, prescaled");
		$display("test prescaled pin done");
		conclude();
	end
endmodule
